// [rtl/ltx_pkg.sv]
// Purpose: shared constants, types and helpers of the transmit diagnostic block
// Assumes: core clock of 20 MHz, one transmit channel per instance
// Notes:   register indexes are word indexes; byte address is four times the index
package ltx_pkg;

   // ==========================================================
   // timing
   localparam int CORE_CLK_NS  = 50;
   localparam int T1_BIT_NS    = 648;
   localparam int E1_BIT_NS    = 488;
   localparam int T1_BIT_CYC   = T1_BIT_NS / CORE_CLK_NS;
   localparam int E1_BIT_CYC   = E1_BIT_NS / CORE_CLK_NS;
   localparam int CLK_LOSS_NS  = 2000;
   localparam int CLK_LOSS_CYC = (CLK_LOSS_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
   localparam int DMO_LIMIT    = 128;
   localparam int SEG_COUNT    = 8;

   // ==========================================================
   // register indexes
   localparam logic [7:0] IDX_T1_ARB = 8'h0D;
   localparam logic [7:0] IDX_E1_ARB = 8'hF4;
   localparam logic [7:0] IDX_CTRL   = 8'h10;
   localparam logic [7:0] IDX_GLOBAL = 8'h11;
   localparam logic [7:0] IDX_BUILD  = 8'h12;
   localparam logic [7:0] IDX_STATUS = 8'h13;
   localparam logic [7:0] IDX_SEG0   = 8'hE0;

   // ==========================================================
   // field positions and reset values
   localparam int CTL_E1       = 0;
   localparam int CTL_ONES     = 1;
   localparam int CTL_PAT_EN   = 2;
   localparam int CTL_PAT_PRBS = 3;
   localparam int CTL_TRI      = 4;
   localparam int CTL_LOOP     = 5;
   localparam int CTL_DMO_IE   = 8;
   localparam int CTL_DUAL     = 9;
   localparam int CTL_RISE     = 10;
   localparam int CTRL_W       = 11;
   localparam int GLB_AUTO     = 0;
   localparam int GLB_LOSS_ONE = 1;
   localparam int ST_ALARM     = 0;
   localparam int ST_CHG       = 1;
   localparam int ST_LOST      = 2;
   localparam int ST_SINGLE    = 3;
   localparam int ARB_SEL      = 0;
   localparam logic [4:0]  BUILD_RESET = 5'h08;
   localparam logic [19:0] LFSR_SEED   = 20'hF_FFFF;

   // ==========================================================
   // pulse shape rows, segment 1 in the top byte
   localparam logic [63:0] ROW_T1_0 = 64'h2421_2020_4C47_4442;
   localparam logic [63:0] ROW_T1_1 = 64'h2923_2221_4E4A_4743;
   localparam logic [63:0] ROW_T1_2 = 64'h3025_2423_5940_4844;
   localparam logic [63:0] ROW_T1_3 = 64'h3426_2423_5F50_4844;
   localparam logic [63:0] ROW_T1_4 = 64'h3928_2523_5950_4844;
   localparam logic [63:0] ROW_E1   = 64'h2C2A_2A00_0000_0000;

   // ==========================================================
   // types
   typedef enum logic [2:0] {
      LOOP_NONE    = 3'b000,
      LOOP_ANALOG  = 3'b001,
      LOOP_REMOTE  = 3'b010,
      LOOP_DIGITAL = 3'b011,
      LOOP_DUAL    = 3'b100
   } ltx_loop_e;

   typedef enum logic [1:0] {
      MARK_NONE = 2'b00,
      MARK_POS  = 2'b01,
      MARK_NEG  = 2'b10
   } ltx_mark_e;

   // ==========================================================
   // shape lookup by build-out code and segment
   function automatic logic [7:0] ltx_rom_seg(input logic       e1,
                                               input logic [4:0] bo,
                                               input logic [2:0] idx);
      logic [63:0] row;
      int          sh;
      row = ROW_T1_0;
      sh  = (SEG_COUNT - 1 - int'(idx)) * 8;
      if (e1) begin
         row = ROW_E1;
      end else if (bo == 5'h09) begin
         row = ROW_T1_1;
      end else if (bo == 5'h0A) begin
         row = ROW_T1_2;
      end else if (bo == 5'h0B) begin
         row = ROW_T1_3;
      end else if (bo == 5'h0C) begin
         row = ROW_T1_4;
      end
      return row[sh +: 8];
   endfunction

   // sign plus clamped 6-bit magnitude
   function automatic logic [6:0] ltx_dac(input logic [7:0] code, input logic neg);
      logic [5:0] mag;
      mag = (code[6:0] > 7'h3F) ? 6'h3F : code[5:0];
      return (mag == 6'h00) ? 7'h00 : {code[7] ^ neg, mag};
   endfunction

endpackage

// [rtl/ltx_tx_diag.sv]
// Purpose: transmit source select, pulse shaper, driver monitor and loopbacks
// Assumes: pins asynchronous to core_clk_i; Avalon-MM slave with waitrequest
// Notes:   line output is a 7-bit signed-magnitude converter code
`timescale 1ns/1ns
module ltx_tx_diag
   import ltx_pkg::*;
#(
   parameter int DMO_LIMIT_P = DMO_LIMIT
) (
   input  wire logic        core_clk_i,
   input  wire logic        rstn_i,
   input  wire logic [9:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        tx_system_clock_i,
   input  wire logic        tx_positive_rail_i,
   input  wire logic        tx_negative_rail_i,
   input  wire logic        receive_signal_loss_i,
   input  wire logic        line_in_tip_i,
   input  wire logic        line_in_ring_i,
   output logic      [6:0]  line_dac_o,
   output logic             line_out_oe_n_o,
   output logic             rx_positive_rail_o,
   output logic             rx_negative_rail_o,
   output logic             rx_clock_o,
   output logic             driver_monitor_alarm_o,
   output logic             dmo_irq_n_o
);

   if (DMO_LIMIT_P < 1 || DMO_LIMIT_P > 254) begin : g_chk
      $error("DMO_LIMIT_P out of range");
   end

   // ==========================================================
   // declarations
   localparam logic [7:0] DMO_LIM8 = 8'(DMO_LIMIT_P);
   localparam logic [7:0] LOSS_CYC = 8'(CLK_LOSS_CYC);
   localparam logic [3:0] T1_CYC   = 4'(T1_BIT_CYC);
   localparam logic [3:0] E1_CYC   = 4'(E1_BIT_CYC);

   logic [5:0]        sync1;
   logic [5:0]        sync2;
   logic              tx_system_clock_d;
   logic [7:0]        t1_arb;
   logic [7:0]        e1_arb;
   logic [7:0]        seg_reg [SEG_COUNT];
   logic [CTRL_W-1:0] ctrl;
   logic [1:0]        glb;
   logic [4:0]        build;
   logic [7:0]        loss_cnt;
   logic [3:0]        bit_cnt;
   logic              seen_pos;
   logic              seen_neg;
   logic              ami_neg;
   logic [19:0]       lfsr;
   logic              seg_active;
   logic [2:0]        seg_idx;
   logic              pulse_neg;
   logic [7:0]        idle_ticks;
   logic              alarm_chg;
   logic              alarm_d;
   logic              tx_system_clock_s, tx_positive_rail_s, tx_negative_rail_s, receive_signal_loss_s, lin_p_s, lin_n_s;
   logic              tx_system_clock_edge, samp_edge, lost, int_tick, tick, bit_last;
   logic              remote, digital, diag, single, arb, pat_bit, acc_rd, acc_wr;
   logic [3:0]        bit_max;
   logic [7:0]        idx;
   ltx_loop_e         loop_mode;
   ltx_mark_e         mark;
   logic [31:0]       rd_mux;

   assign {tx_system_clock_s, tx_positive_rail_s, tx_negative_rail_s, receive_signal_loss_s, lin_p_s, lin_n_s} = sync2;
   assign loop_mode = ltx_loop_e'(ctrl[CTL_LOOP +: 3]);
   assign idx       = avs_address_i[9:2];
   assign acc_rd    = avs_read_i && !avs_waitrequest_o;
   assign acc_wr    = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];

   // ==========================================================
   // pin synchronisers
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1 <= 6'h00;
         sync2 <= 6'h00;
      end else begin
         sync1 <= {tx_system_clock_i, tx_positive_rail_i, tx_negative_rail_i,
                   receive_signal_loss_i, line_in_tip_i, line_in_ring_i};
         sync2 <= sync1;
      end
   end

   // ==========================================================
   // register bus, two cycles per access
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (idx == IDX_T1_ARB) begin
         rd_mux[7:0] = t1_arb;
      end else if (idx == IDX_E1_ARB) begin
         rd_mux[7:0] = e1_arb;
      end else if (idx == IDX_CTRL) begin
         rd_mux[CTRL_W-1:0] = ctrl;
      end else if (idx == IDX_GLOBAL) begin
         rd_mux[1:0] = glb;
      end else if (idx == IDX_BUILD) begin
         rd_mux[4:0] = build;
      end else if (idx == IDX_STATUS) begin
         rd_mux[ST_ALARM]  = driver_monitor_alarm_o;
         rd_mux[ST_CHG]    = alarm_chg;
         rd_mux[ST_LOST]   = lost;
         rd_mux[ST_SINGLE] = single;
      end else if (idx[7:3] == IDX_SEG0[7:3]) begin
         rd_mux[7:0] = seg_reg[idx[2:0]];
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (avs_read_i && avs_waitrequest_o) begin
         avs_readdata_o <= rd_mux;
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         t1_arb <= 8'h00;
         e1_arb <= 8'h00;
         ctrl   <= '0;
         glb    <= 2'b00;
         build  <= BUILD_RESET;
         for (int i = 0; i < SEG_COUNT; i++) begin
            seg_reg[i] <= 8'h00;
         end
      end else if (acc_wr) begin
         if (idx == IDX_T1_ARB) begin
            t1_arb <= avs_writedata_i[7:0];
         end else if (idx == IDX_E1_ARB) begin
            e1_arb <= avs_writedata_i[7:0];
         end else if (idx == IDX_CTRL) begin
            ctrl <= avs_writedata_i[CTRL_W-1:0];
         end else if (idx == IDX_GLOBAL) begin
            glb <= avs_writedata_i[1:0];
         end else if (idx == IDX_BUILD) begin
            build <= avs_writedata_i[4:0];
         end else if (idx[7:3] == IDX_SEG0[7:3]) begin
            seg_reg[idx[2:0]] <= avs_writedata_i[7:0];
         end
      end
   end

   // ==========================================================
   // transmit clock edges, loss and bit timing
   assign tx_system_clock_edge = tx_system_clock_s ^ tx_system_clock_d;
   assign samp_edge = ctrl[CTL_RISE] ? (tx_system_clock_s && !tx_system_clock_d) : (!tx_system_clock_s && tx_system_clock_d);
   assign lost      = (loss_cnt >= LOSS_CYC);
   assign bit_max   = ctrl[CTL_E1] ? E1_CYC : T1_CYC;
   assign bit_last  = (bit_cnt >= bit_max - 4'd1);
   assign int_tick  = bit_last;
   assign remote    = (loop_mode == LOOP_REMOTE) || (loop_mode == LOOP_DUAL);
   assign digital   = (loop_mode == LOOP_DIGITAL) || (loop_mode == LOOP_DUAL);
   assign tick      = (lost || remote) ? int_tick : samp_edge;

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tx_system_clock_d   <= 1'b0;
         loss_cnt <= 8'h00;
         bit_cnt  <= 4'h0;
      end else begin
         tx_system_clock_d   <= tx_system_clock_s;
         loss_cnt <= tx_system_clock_edge ? 8'h00 : (lost ? loss_cnt : loss_cnt + 8'd1);
         bit_cnt  <= bit_last ? 4'h0 : bit_cnt + 4'd1;
      end
   end

   // received marks gathered per bit period
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         seen_pos <= 1'b0;
         seen_neg <= 1'b0;
      end else begin
         seen_pos <= lin_p_s || (seen_pos && !int_tick);
         seen_neg <= lin_n_s || (seen_neg && !int_tick);
      end
   end

   // ==========================================================
   // source selection
   // generated patterns force single rail
   assign diag   = ctrl[CTL_ONES] || (glb[GLB_AUTO] && receive_signal_loss_s) || ctrl[CTL_PAT_EN];
   assign single = diag || !ctrl[CTL_DUAL];

   assign pat_bit = ctrl[CTL_PAT_PRBS] ? (lfsr[14] ^ lfsr[13]) : (lfsr[19] ^ lfsr[16]);

   always_comb begin
      mark = MARK_NONE;
      // remote and dual loopback come first
      if (remote) begin
         if (seen_pos || lin_p_s) begin
            mark = MARK_POS;
         end else if (seen_neg || lin_n_s) begin
            mark = MARK_NEG;
         end
      end else if (lost) begin
         if (glb[GLB_LOSS_ONE]) begin
            mark = ami_neg ? MARK_NEG : MARK_POS;
         end
      end else if (ctrl[CTL_ONES] || (glb[GLB_AUTO] && receive_signal_loss_s)) begin
         mark = ami_neg ? MARK_NEG : MARK_POS;
      end else if (ctrl[CTL_PAT_EN]) begin
         if (pat_bit) begin
            mark = ami_neg ? MARK_NEG : MARK_POS;
         end
      end else if (!single) begin
         if (tx_positive_rail_s && !tx_negative_rail_s) begin
            mark = MARK_POS;
         end else if (tx_negative_rail_s && !tx_positive_rail_s) begin
            mark = MARK_NEG;
         end
      end else if (tx_positive_rail_s) begin
         mark = ami_neg ? MARK_NEG : MARK_POS;
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lfsr    <= LFSR_SEED;
         ami_neg <= 1'b0;
      end else if (tick) begin
         if (ctrl[CTL_PAT_EN]) begin
            lfsr <= {lfsr[18:0], pat_bit};
         end
         if (mark != MARK_NONE) begin
            ami_neg <= (mark == MARK_POS);
         end
      end
   end

   // ==========================================================
   // pulse shaper
   assign arb = ctrl[CTL_E1] ? e1_arb[ARB_SEL] : t1_arb[ARB_SEL];

   // segments 1 to 8 in turn
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         seg_active <= 1'b0;
         seg_idx    <= 3'h0;
         pulse_neg  <= 1'b0;
      end else if (tick && mark != MARK_NONE) begin
         seg_active <= 1'b1;
         seg_idx    <= 3'h0;
         pulse_neg  <= (mark == MARK_NEG);
      end else if (seg_active) begin
         seg_active <= (seg_idx != 3'h7);
         seg_idx    <= seg_idx + 3'd1;
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         line_dac_o      <= 7'h00;
         line_out_oe_n_o <= 1'b1;
      end else begin
         line_out_oe_n_o <= ctrl[CTL_TRI];
         if (!seg_active) begin
            line_dac_o <= 7'h00;
         end else if (arb) begin
            line_dac_o <= ltx_dac(seg_reg[seg_idx], pulse_neg);
         end else begin
            line_dac_o <= ltx_dac(ltx_rom_seg(ctrl[CTL_E1], build, seg_idx), pulse_neg);
         end
      end
   end

   // ==========================================================
   // driver monitor
   // count idle bit periods
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         idle_ticks             <= 8'h00;
         driver_monitor_alarm_o <= 1'b0;
      end else if (tick) begin
         if (mark != MARK_NONE && !ctrl[CTL_TRI]) begin
            idle_ticks             <= 8'h00;
            driver_monitor_alarm_o <= 1'b0;
         end else if (idle_ticks == DMO_LIM8) begin
            driver_monitor_alarm_o <= 1'b1;
         end else begin
            idle_ticks <= idle_ticks + 8'd1;
         end
      end
   end

   // change flag, set wins over read clear
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         alarm_d     <= 1'b0;
         alarm_chg   <= 1'b0;
         dmo_irq_n_o <= 1'b1;
      end else begin
         alarm_d     <= driver_monitor_alarm_o;
         alarm_chg   <= (alarm_d != driver_monitor_alarm_o) ||
                        (alarm_chg && !(acc_rd && idx == IDX_STATUS));
         dmo_irq_n_o <= !(alarm_chg && ctrl[CTL_DMO_IE]);
      end
   end

   // ==========================================================
   // receive side and loopbacks
   // receive rail selection
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_positive_rail_o <= 1'b0;
         rx_negative_rail_o <= 1'b0;
         rx_clock_o         <= 1'b0;
      end else if (digital) begin
         rx_positive_rail_o <= tx_positive_rail_s;
         rx_negative_rail_o <= tx_negative_rail_s;
         rx_clock_o         <= tx_system_clock_s;
      end else begin
         rx_clock_o <= (bit_cnt < (bit_max >> 1));
         if (loop_mode == LOOP_ANALOG) begin
            rx_positive_rail_o <= seg_active && !pulse_neg;
            rx_negative_rail_o <= seg_active && pulse_neg;
         end else begin
            rx_positive_rail_o <= lin_p_s;
            rx_negative_rail_o <= lin_n_s;
         end
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);

   property p_tristate;
      ctrl[CTL_TRI] |=> line_out_oe_n_o;
   endproperty
   a_tristate: assert property (p_tristate)
      else $error("driver not released while tri-state set");

   property p_seg_order;
      seg_active && seg_idx != 3'h7 && !tick |=> seg_active && seg_idx == $past(seg_idx) + 3'd1;
   endproperty
   a_seg_order: assert property (p_seg_order)
      else $error("segment order broken");

   property p_ones;
      tick && !remote && !lost && ctrl[CTL_ONES] |=> seg_active && seg_idx == 3'h0;
   endproperty
   a_ones: assert property (p_ones)
      else $error("forced ones produced no pulse");

   property p_loss_zero;
      tick && lost && !remote && !glb[GLB_LOSS_ONE] |-> mark == MARK_NONE;
   endproperty
   a_loss_zero: assert property (p_loss_zero)
      else $error("pulse sent on lost clock in zeros mode");

   property p_single;
      ctrl[CTL_PAT_EN] |-> single;
   endproperty
   a_single: assert property (p_single)
      else $error("pattern not in single rail");

   property p_full;
      seg_active && arb && seg_reg[seg_idx][6:0] == 7'h7F |=> line_dac_o[5:0] == 6'h3F;
   endproperty
   a_full: assert property (p_full)
      else $error("full scale code not at full amplitude");

   property p_alarm_clear;
      tick && mark != MARK_NONE && !ctrl[CTL_TRI] |=> !driver_monitor_alarm_o;
   endproperty
   a_alarm_clear: assert property (p_alarm_clear)
      else $error("alarm kept after valid pulse");

   property p_irq;
      ctrl[CTL_DMO_IE] && $changed(driver_monitor_alarm_o) |-> ##[1:2] !dmo_irq_n_o;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt not raised on alarm change");

   property p_digital;
      digital |=> rx_positive_rail_o == $past(tx_positive_rail_s) && rx_clock_o == $past(tx_system_clock_s);
   endproperty
   a_digital: assert property (p_digital)
      else $error("digital loopback rails wrong");

   c_ones:   cover property (tick && ctrl[CTL_ONES] && mark != MARK_NONE);
   c_alarm:  cover property ($rose(driver_monitor_alarm_o));
   c_remote: cover property (remote && tick && mark != MARK_NONE);
   c_prbs:   cover property (ctrl[CTL_PAT_EN] && ctrl[CTL_PAT_PRBS] && seg_active);

endmodule // ltx_tx_diag

// [testbench/ltx_framer_model.sv]
// Purpose: framer model driving the transmit clock and rails
// Assumes: link clock period 400 ns, data launched on its rising edge
// Notes:   clock stands low while run_i is low
`timescale 1ns/1ns
module ltx_framer_model (
   input  wire logic run_i,
   input  wire logic pos_i,
   output logic      tx_system_clock_o,
   output logic      tx_positive_rail_o,
   output logic      tx_negative_rail_o
);
   // ====================
   // link clock and rails
   initial begin
      tx_system_clock_o = 1'b0;
      tx_positive_rail_o = 1'b0;
      tx_negative_rail_o = 1'b0;
      forever begin
         #200;
         tx_system_clock_o = run_i & ~tx_system_clock_o;
         if (tx_system_clock_o) begin
            tx_positive_rail_o = pos_i;
         end
      end
   end
endmodule // ltx_framer_model

// [testbench/ltx_tx_diag_tb.sv]
// Purpose: self-checking bench of the transmit diagnostic block
// Assumes: 50 ns core clock, alarm limit shortened to 4 ticks
// Notes:   segment 1 code 7F, other segment codes random from a fixed seed
`timescale 1ns/1ns
module ltx_tx_diag_tb;
   import ltx_pkg::*;
   logic        clk, rstn, rd_s, wr_s, rsl, tip, run, pos, seen, seen_rx;
   logic        wait_o, oe_n, rxp, rxn, rxc, alarm, irq_n, tx_system_clock, tx_positive_rail, tx_negative_rail;
   logic [3:0]  hist;
   logic [9:0]  addr;
   logic [31:0] wdat, rdat, rdo;
   logic [6:0]  dac;
   logic [63:0] row;
   logic [7:0]  s;
   int          n_fail, samples_checked;
   logic [63:0] rom [5] = '{ROW_T1_0, ROW_T1_1, ROW_T1_2, ROW_T1_3, ROW_T1_4};
   logic [7:0]  ix [5] = '{IDX_T1_ARB, IDX_E1_ARB, IDX_GLOBAL, IDX_BUILD, 8'h20};
   // ====================
   // clock, partner, design
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   ltx_framer_model u_fr (.run_i(run), .pos_i(pos), .tx_system_clock_o(tx_system_clock), .tx_positive_rail_o(tx_positive_rail), .tx_negative_rail_o(tx_negative_rail));
   ltx_tx_diag #(.DMO_LIMIT_P(4)) dut (
      .core_clk_i(clk), .rstn_i(rstn), .avs_address_i(addr), .avs_read_i(rd_s),
      .avs_write_i(wr_s), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
      .avs_readdata_o(rdo), .avs_waitrequest_o(wait_o), .tx_system_clock_i(tx_system_clock),
      .tx_positive_rail_i(tx_positive_rail), .tx_negative_rail_i(tx_negative_rail), .receive_signal_loss_i(rsl),
      .line_in_tip_i(tip), .line_in_ring_i(1'b0), .line_dac_o(dac), .line_out_oe_n_o(oe_n),
      .rx_positive_rail_o(rxp), .rx_negative_rail_o(rxn), .rx_clock_o(rxc),
      .driver_monitor_alarm_o(alarm), .dmo_irq_n_o(irq_n));
   // ====================
   // helpers
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
      @(posedge clk);
      addr <= {i, 2'b00};
      wdat <= d;
      wr_s <= w;
      rd_s <= ~w;
      do begin
         @(posedge clk);
      end while (wait_o !== 1'b0);
      rdat = rdo;
      wr_s <= 1'b0;
      rd_s <= 1'b0;
   endtask
   task automatic look(input int n);
      seen = 1'b0;
      seen_rx = 1'b0;
      repeat (n) begin
         @(posedge clk);
         if (dac !== 7'h0) seen = 1'b1;
         if (rxp === 1'b1 || rxn === 1'b1) seen_rx = 1'b1;
      end
   endtask
   function automatic logic [6:0] code(input logic [7:0] c, input logic neg);
      logic [5:0] m;
      m = c[6] ? 6'h3F : c[5:0];
      return (m == 6'h0) ? 7'h0 : {c[7] ^ neg, m};
   endfunction
   task automatic shape(input logic [63:0] r);
      logic neg;
      int   n;
      n = 0;
      repeat (20) @(posedge clk);
      pos <= 1'b1;
      repeat (8) @(posedge clk);
      pos <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (dac === 7'h0 && n < 100);
      neg = dac[6] ^ r[63];
      for (int i = 0; i < 8; i++) begin
         chk(32'(dac), 32'(code(r[63 - 8 * i -: 8], neg)));
         @(posedge clk);
      end
   endtask
   task automatic conclude();
      $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ====================
   // watchdog
   initial begin
      #1_500_000;
      n_fail++;
      conclude();
   end
   // ====================
   // main sequence
   initial begin
      {rstn, rd_s, wr_s, rsl, tip, pos, addr, wdat} = '0;
      run = 1'b1;
      n_fail = 0;
      samples_checked = 0;
      rdat = $urandom(32'h2e06_3e83);
      repeat (6) @(posedge clk);
      chk(32'({wait_o, alarm, irq_n, oe_n, dac}), 32'h5 << 8 | 32'h80);
      rstn <= 1'b1;
      bus(1'b1, IDX_CTRL, 32'h100);
      bus(1'b1, 8'h20, 32'hFF);
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, ix[i], 32'h0);
         chk(rdat, (ix[i] == IDX_BUILD) ? 32'h8 : 32'h0);
      end
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, IDX_SEG0 + 8'(i), 32'h0);
         chk(rdat, 32'h0);
      end
      repeat (60) @(posedge clk);
      chk(32'({alarm, irq_n}), 32'h2);
      bus(1'b0, IDX_STATUS, 32'h0);
      chk(rdat, 32'hB);
      repeat (3) @(posedge clk);
      chk(32'(irq_n), 32'h1);
      bus(1'b1, IDX_CTRL, 32'h102);
      repeat (100) @(posedge clk);
      chk(32'({alarm, irq_n}), 32'h0);
      bus(1'b0, IDX_STATUS, 32'h0);
      chk(rdat, 32'hA);
      bus(1'b1, IDX_CTRL, 32'h2);
      bus(1'b1, IDX_T1_ARB, 32'h1);
      repeat (2) @(posedge clk);
      look(100);
      chk(32'(seen), 32'h0);
      for (int i = 0; i < 8; i++) begin
         s = (i == 0) ? 8'h7F : 8'($urandom);
         row = {row[55:0], s};
         bus(1'b1, IDX_SEG0 + 8'(i), 32'(s));
         bus(1'b0, IDX_SEG0 + 8'(i), 32'h0);
         chk(rdat, 32'(s));
      end
      bus(1'b1, IDX_CTRL, 32'h0);
      shape(row);
      bus(1'b1, IDX_CTRL, 32'h1);
      bus(1'b1, IDX_E1_ARB, 32'h1);
      shape(row);
      bus(1'b1, IDX_E1_ARB, 32'h0);
      bus(1'b1, IDX_T1_ARB, 32'h0);
      shape(ROW_E1);
      bus(1'b1, IDX_CTRL, 32'h0);
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, IDX_BUILD, 32'h8 + 32'(i));
         shape(rom[i]);
      end
      bus(1'b1, IDX_CTRL, 32'h12);
      repeat (5) @(posedge clk);
      chk(32'(oe_n), 32'h1);
      for (int j = 0; j < 4; j++) begin
         bus(1'b1, IDX_CTRL, 32'h204 | 32'(j[0]) << 3 | (j[1] ? 32'h60 : 32'h0));
         look(200);
         chk(32'(seen), 32'h1);
         bus(1'b0, IDX_STATUS, 32'h0);
         chk(32'(rdat[3]), 32'h1);
      end
      chk(32'(oe_n), 32'h0);
      pos <= 1'b1;
      bus(1'b1, IDX_CTRL, 32'h60);
      look(100);
      chk(32'({seen, rxp}), 32'h3);
      hist = 4'h0;
      for (int k = 0; k < 16; k++) begin
         @(posedge clk);
         hist = {hist[2:0], tx_system_clock};
         if (k > 3) chk(32'(rxc), 32'(hist[3]));
      end
      for (int j = 0; j < 2; j++) begin
         pos <= j[0];
         bus(1'b1, IDX_CTRL, j ? 32'h82 : 32'h42);
         repeat (24) @(posedge clk);
         look(100);
         chk(32'(seen), 32'h0);
         chk(32'(rxp), 32'(j));
         tip <= 1'b1;
         look(100);
         chk(32'(seen), 32'h1);
         tip <= 1'b0;
      end
      pos <= 1'b0;
      bus(1'b1, IDX_CTRL, 32'h22);
      look(100);
      chk(32'({seen, seen_rx}), 32'h3);
      run <= 1'b0;
      bus(1'b1, IDX_CTRL, 32'h2);
      repeat (60) @(posedge clk);
      look(100);
      chk(32'(seen), 32'h0);
      bus(1'b0, IDX_STATUS, 32'h0);
      chk(32'(rdat[2]), 32'h1);
      bus(1'b1, IDX_GLOBAL, 32'h2);
      look(100);
      chk(32'(seen), 32'h1);
      run <= 1'b1;
      bus(1'b1, IDX_CTRL, 32'h0);
      bus(1'b1, IDX_GLOBAL, 32'h1);
      rsl <= 1'b1;
      look(100);
      chk(32'(seen), 32'h1);
      rsl <= 1'b0;
      repeat (40) @(posedge clk);
      look(100);
      chk(32'(seen), 32'h0);
      conclude();
   end
endmodule // ltx_tx_diag_tb
